// file: hw/ewl_core.sv
// Two-wire slave engine with select-address and array write-lock register
//
// Overview of operation
// R1 - One eight-bit nonvolatile configuration register kept
// R2 - Upper four register bits affect nothing
// R3 - Bits three to one form select address
// R4 - Bit zero set makes array read-only
// R5 - Register reached by type code and address
// R6 - Written select bits compared against select codes
// R7 - Stored select bits loaded at power-up, reprogramming
// R8 - Stored lock bit restored at power-up
// R9 - Lock bit may be set and cleared
// R10 - Locked: select, address acked; array data not acked
// R11 - Device is slave only; master clocks
// R12 - Sample and launch data on serial clock
// R13 - Data line driven open-drain only
// R14 - Reset leaves standby, ignores bus meanwhile
// R15 - Reset again stops all responses
// R16 - Stop without write cycle enters standby
// R17 - Ack select code only on address match
// R18 - Top address bit routes to register
// R19 - Register writes ignore the lock bit
// R20 - New select takes effect after write completes
// R21 - Register read returns stored bits in place
`timescale 1ns/1ps

module ewl_core #(
   parameter int WRITE_CYCLES = ewl_pkg::WRITE_CYCLES,
   parameter logic [3:0] DEV_TYPE = ewl_pkg::DEV_TYPE_DEFAULT
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic [7:0] nvmCfgIn,
   output logic nvmCfgWr,
   output logic [7:0] nvmCfgData,
   output logic [15:0] memAddr,
   output logic [7:0] memWrData,
   output logic memWrEn,
   input wire logic [7:0] memRdData,
   output logic [2:0] selectAddr,
   output logic writeLocked,
   output logic writeBusy
);

   localparam int BUSY_W = $clog2(WRITE_CYCLES + 1);

   // Refuse a write time the counter cannot serve
   if (WRITE_CYCLES < 1) begin : g_bad_write_cycles
      $error("WRITE_CYCLES must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic sclMeta_r, sclSync_r, sclDly_r, sdaMeta_r, sdaSync_r, sdaDly_r;
   logic sdaBit, linkPull;
   ewl_pkg::ewl_state_e state_r, state_nxt;
   logic [3:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] shift_r, shift_nxt, txShift_r, txShift_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic drvLow_r, drvLow_nxt, rw_r, rw_nxt, dataSlot_r, dataSlot_nxt;
   logic [7:0] cfg_r, cfg_nxt, pendCfg_r, pendCfg_nxt, memWrData_r, memWrData_nxt;
   logic cfgPend_r, cfgPend_nxt, arrayPend_r, arrayPend_nxt;
   logic [BUSY_W-1:0] busyCnt_r, busyCnt_nxt;
   logic cfgLoad_r, cfgLoad_nxt, memWrEn_r, memWrEn_nxt, nvmWr_r, nvmWr_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Address arithmetic

   // Page writes roll over inside the page; reads run through the array
   function automatic logic [15:0] next_addr(input logic [15:0] a, input logic page);
      logic [15:0] r;
      r = a;
      if (page) begin
         r[ewl_pkg::PAGE_BITS-1:0] = a[ewl_pkg::PAGE_BITS-1:0] + 5'h01;
      end else begin
         r[ewl_pkg::CFG_ADDR_BIT-1:0] = a[ewl_pkg::CFG_ADDR_BIT-1:0] + 15'h0001;
      end
      return r;
   endfunction : next_addr

   ////////////////////////////////////////////////////////////////////////////
   // Link clock domain

   // Sampling and launching on the master's own serial clock
   ewl_link u_link (
      .scl(scl),
      .sdaIn(sdaIn),
      .driveLow(drvLow_r),
      .sdaSample(sdaBit),
      .sdaPull(linkPull)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and condition decode

   // Two flops per pin, a third for edge history
   always_ff @(posedge mclk) begin
      sclMeta_r <= scl;
      sclSync_r <= sclMeta_r;
      sclDly_r <= sclSync_r;
      sdaMeta_r <= sdaIn;
      sdaSync_r <= sdaMeta_r;
      sdaDly_r <= sdaSync_r;
   end

   // Start and stop seen while the clock stays high
   wire sclRise = sclSync_r & ~sclDly_r;
   wire startSeen = sclSync_r & sclDly_r & sdaDly_r & ~sdaSync_r;
   wire stopSeen = sclSync_r & sclDly_r & ~sdaDly_r & sdaSync_r;

   // Byte assembly and select decode
   wire [7:0] byteIn = {shift_r[6:0], sdaBit};
   wire typeMatch = byteIn[ewl_pkg::TYPE_MSB:ewl_pkg::TYPE_LSB] == DEV_TYPE;
   wire selMatch = byteIn[ewl_pkg::SEL_MSB:ewl_pkg::SEL_LSB]
      == cfg_r[ewl_pkg::SEL_MSB:ewl_pkg::SEL_LSB]; // [R3] [R6] [R17]
   wire lockOn = cfg_r[ewl_pkg::LOCK_BIT]; // [R4]
   wire cfgTarget = addr_r[ewl_pkg::CFG_ADDR_BIT]; // [R18]
   wire [7:0] rdByte = cfgTarget ? cfg_r : memRdData; // [R21] [R5]
   wire linkActive = (state_r != ewl_pkg::ST_STANDBY) && (state_r != ewl_pkg::ST_BUSY);

   ////////////////////////////////////////////////////////////////////////////
   // Protocol engine

   // Next-state and datapath decisions, one serial event at a time
   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      shift_nxt = shift_r;
      txShift_nxt = txShift_r;
      addr_nxt = addr_r;
      drvLow_nxt = drvLow_r;
      rw_nxt = rw_r;
      dataSlot_nxt = dataSlot_r;
      cfg_nxt = cfg_r;
      pendCfg_nxt = pendCfg_r;
      cfgPend_nxt = cfgPend_r;
      arrayPend_nxt = arrayPend_r;
      busyCnt_nxt = busyCnt_r;
      cfgLoad_nxt = 1'b0;
      memWrEn_nxt = 1'b0;
      memWrData_nxt = memWrData_r;
      nvmWr_nxt = 1'b0;
      if (cfgLoad_r) begin
         cfg_nxt = nvmCfgIn; // [R1] [R7] [R8]
      end else if (state_r == ewl_pkg::ST_BUSY) begin
         // Deaf until the internal write ends
         drvLow_nxt = 1'b0;
         if (busyCnt_r == '0) begin
            state_nxt = ewl_pkg::ST_STANDBY; // [R16]
            cfg_nxt = cfgPend_r ? pendCfg_r : cfg_r; // [R20] [R7] [R9]
            cfgPend_nxt = 1'b0;
            arrayPend_nxt = 1'b0;
         end else begin
            busyCnt_nxt = busyCnt_r - 1'b1;
         end
      end else if (startSeen) begin
         // Start or repeated start drops the pending write cycle and register update; array bytes already pulsed stay
         state_nxt = ewl_pkg::ST_DEVSEL;
         bitCnt_nxt = 4'h0;
         drvLow_nxt = 1'b0;
         dataSlot_nxt = 1'b0;
         cfgPend_nxt = 1'b0;
         arrayPend_nxt = 1'b0;
      end else if (stopSeen) begin
         drvLow_nxt = 1'b0;
         if (state_r == ewl_pkg::ST_WDATA && dataSlot_r && (cfgPend_r || arrayPend_r)) begin
            state_nxt = ewl_pkg::ST_BUSY;
            busyCnt_nxt = BUSY_W'(WRITE_CYCLES - 1);
            nvmWr_nxt = cfgPend_r; // [R1]
         end else begin
            state_nxt = ewl_pkg::ST_STANDBY; // [R16]
            cfgPend_nxt = 1'b0;
            arrayPend_nxt = 1'b0;
         end
      end else if (sclRise && linkActive) begin
         // Slot flag survives only the clock after the ack, where a stop may land
         dataSlot_nxt = dataSlot_r & (bitCnt_r == 4'h0); // [R16]
         if (bitCnt_r != ewl_pkg::ACK_SLOT) begin
            bitCnt_nxt = bitCnt_r + 4'h1;
            shift_nxt = byteIn;
            if (state_r == ewl_pkg::ST_RDATA) begin
               if (bitCnt_r == ewl_pkg::LAST_DATA_BIT) begin
                  // Release for the master's acknowledge; prefetch next address
                  drvLow_nxt = 1'b0;
                  addr_nxt = cfgTarget ? addr_r : next_addr(addr_r, 1'b0);
               end else begin
                  drvLow_nxt = ~txShift_r[7]; // [R13]
                  txShift_nxt = {txShift_r[6:0], 1'b1};
               end
            end else if (bitCnt_r == ewl_pkg::LAST_DATA_BIT) begin
               case (state_r)
                  ewl_pkg::ST_DEVSEL: begin
                     if (typeMatch && selMatch) begin
                        drvLow_nxt = 1'b1; // [R17] [R5]
                        rw_nxt = byteIn[ewl_pkg::RW_BIT];
                     end else begin
                        state_nxt = ewl_pkg::ST_STANDBY; // [R17]
                     end
                  end
                  ewl_pkg::ST_ADDRHI: begin
                     addr_nxt[15:8] = byteIn;
                     drvLow_nxt = 1'b1; // [R10]
                  end
                  ewl_pkg::ST_ADDRLO: begin
                     addr_nxt[7:0] = byteIn;
                     drvLow_nxt = 1'b1; // [R10]
                  end
                  ewl_pkg::ST_WDATA: begin
                     if (cfgTarget) begin
                        pendCfg_nxt = byteIn; // [R19] [R2] [R6] [R9]
                        cfgPend_nxt = 1'b1;
                        drvLow_nxt = 1'b1;
                     end else if (lockOn) begin
                        drvLow_nxt = 1'b0; // [R10] [R4]
                     end else begin
                        memWrEn_nxt = 1'b1;
                        memWrData_nxt = byteIn;
                        arrayPend_nxt = 1'b1;
                        drvLow_nxt = 1'b1;
                     end
                  end
                  default: begin
                     drvLow_nxt = 1'b0;
                  end
               endcase
            end
         end else begin
            // Ninth clock: acknowledge slot ends
            bitCnt_nxt = 4'h0;
            drvLow_nxt = 1'b0;
            case (state_r)
               ewl_pkg::ST_DEVSEL: begin
                  if (rw_r) begin
                     state_nxt = ewl_pkg::ST_RDATA;
                     drvLow_nxt = ~rdByte[7]; // [R21]
                     txShift_nxt = {rdByte[6:0], 1'b1};
                  end else begin
                     state_nxt = ewl_pkg::ST_ADDRHI;
                  end
               end
               ewl_pkg::ST_ADDRHI: begin
                  state_nxt = ewl_pkg::ST_ADDRLO;
               end
               ewl_pkg::ST_ADDRLO: begin
                  state_nxt = ewl_pkg::ST_WDATA;
               end
               ewl_pkg::ST_WDATA: begin
                  dataSlot_nxt = 1'b1;
                  addr_nxt = (cfgTarget || lockOn) ? addr_r : next_addr(addr_r, 1'b1);
               end
               ewl_pkg::ST_RDATA: begin
                  if (!sdaBit) begin
                     drvLow_nxt = ~rdByte[7];
                     txShift_nxt = {rdByte[6:0], 1'b1};
                  end else begin
                     state_nxt = ewl_pkg::ST_STANDBY;
                  end
               end
               default: begin
                  state_nxt = ewl_pkg::ST_STANDBY;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers

   // Protocol state; reset parks the engine in standby
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_r <= ewl_pkg::ST_STANDBY; // [R14] [R15]
         bitCnt_r <= 4'h0;
         drvLow_r <= 1'b0;
         rw_r <= 1'b0;
         dataSlot_r <= 1'b0;
         cfgPend_r <= 1'b0;
         arrayPend_r <= 1'b0;
         busyCnt_r <= '0;
         cfgLoad_r <= 1'b1; // [R7] [R8]
         memWrEn_r <= 1'b0;
         nvmWr_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         drvLow_r <= drvLow_nxt;
         rw_r <= rw_nxt;
         dataSlot_r <= dataSlot_nxt;
         cfgPend_r <= cfgPend_nxt;
         arrayPend_r <= arrayPend_nxt;
         busyCnt_r <= busyCnt_nxt;
         cfgLoad_r <= cfgLoad_nxt;
         memWrEn_r <= memWrEn_nxt;
         nvmWr_r <= nvmWr_nxt;
      end
   end

   // Datapath registers
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         shift_r <= 8'h00;
         txShift_r <= 8'hff;
         addr_r <= 16'h0000;
         cfg_r <= ewl_pkg::CFG_RESET;
         pendCfg_r <= ewl_pkg::CFG_RESET;
         memWrData_r <= 8'h00;
      end else begin
         shift_r <= shift_nxt;
         txShift_r <= txShift_nxt;
         addr_r <= addr_nxt;
         cfg_r <= cfg_nxt;
         pendCfg_r <= pendCfg_nxt;
         memWrData_r <= memWrData_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Open drain: only ever pull low, and only while engaged on the bus
   assign sdaOut = 1'b0; // [R13]
   assign sdaOe = linkPull & linkActive; // [R13] [R11] [R15]
   assign nvmCfgWr = nvmWr_r;
   assign nvmCfgData = pendCfg_r;
   assign memAddr = addr_r;
   assign memWrData = memWrData_r;
   assign memWrEn = memWrEn_r;
   assign selectAddr = cfg_r[ewl_pkg::SEL_MSB:ewl_pkg::SEL_LSB];
   assign writeLocked = cfg_r[ewl_pkg::LOCK_BIT];
   assign writeBusy = (state_r == ewl_pkg::ST_BUSY);

endmodule : ewl_core

// file: hw/ewl_pkg.sv
// Shared constants and types for the select-address and write-lock block
package ewl_pkg;

   // Configuration register layout
   localparam int CFG_W = 8;
   localparam int LOCK_BIT = 0;
   localparam int SEL_LSB = 1;
   localparam int SEL_MSB = 3;
   localparam int SEL_W = 3;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // Device select byte layout
   localparam int TYPE_LSB = 4;
   localparam int TYPE_MSB = 7;
   localparam int RW_BIT = 0;
   // Device type code; value is arbitrary
   localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;

   // Address layout
   localparam int ADDR_W = 16;
   localparam int CFG_ADDR_BIT = 15;
   localparam int PAGE_BITS = 5;

   // Bit counting within one byte plus acknowledge slot
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   // Internal write cycle time
   localparam int CLK_MHZ = 100;
   localparam int WRITE_TIME_MS = 5;
   localparam int WRITE_CYCLES = WRITE_TIME_MS * CLK_MHZ * 1000;

   // Protocol states
   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_DEVSEL,
      ST_ADDRHI,
      ST_ADDRLO,
      ST_WDATA,
      ST_RDATA,
      ST_BUSY
   } ewl_state_e;

endpackage : ewl_pkg

// file: hw/ewl_link.sv
// Serial-clock domain front end: samples data and launches the pull-down
`timescale 1ns/1ps

module ewl_link (
   scl,
   sdaIn,
   driveLow,
   sdaSample,
   sdaPull
);
   input wire logic scl;
   input wire logic sdaIn;
   input wire logic driveLow;
   output logic sdaSample;
   output logic sdaPull;

   logic sample_r;
   logic pull_r;

   // Incoming data taken on the rising serial clock edge
   always_ff @(posedge scl) begin
      sample_r <= sdaIn; // [R12]
   end

   // Pull-down launched on the falling edge; decision settled long before
   always_ff @(negedge scl) begin
      pull_r <= driveLow; // [R12]
   end

   assign sdaSample = sample_r;
   assign sdaPull = pull_r;

endmodule : ewl_link

// file: bench/ewl_core_props.sv
// Port checks for the select-address and write-lock engine
`timescale 1ns/1ps

module ewl_core_props #(
   parameter int WRITE_CYCLES = 50
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic scl,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic [7:0] nvmCfgIn,
   input wire logic nvmCfgWr,
   input wire logic [15:0] memAddr,
   input wire logic memWrEn,
   input wire logic [2:0] selectAddr,
   input wire logic writeLocked,
   input wire logic writeBusy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic [31:0] busyCnt_r;
   logic inReset_r = 1'b0;

   // Length of the running write cycle
   always_ff @(posedge mclk) begin
      if (!reset_n || !writeBusy) begin
         busyCnt_r <= 32'h0;
      end else begin
         busyCnt_r <= busyCnt_r + 32'h1;
      end
   end

   // Reset already seen at the previous edge
   always_ff @(posedge mclk) begin
      inReset_r <= !reset_n;
   end

   a_sda_open_drain: assert property (sdaOut == 1'b0)
      else $error("data line driven high");
   a_lock_no_write: assert property (writeLocked |-> !memWrEn)
      else $error("array written while locked");
   a_cfg_not_array: assert property (memWrEn |-> !memAddr[15])
      else $error("register address reached the array");
   a_prog_then_busy: assert property (nvmCfgWr |=> writeBusy && !nvmCfgWr)
      else $error("program pulse without write cycle");
   a_sel_change_cause: assert property ($changed({selectAddr, writeLocked})
      |-> $past(writeBusy) || !$past(reset_n, 2))
      else $error("select or lock changed outside a write cycle");
   a_load_on_release: assert property ($rose(reset_n)
      |=> {selectAddr, writeLocked} == $past(nvmCfgIn[3:0]))
      else $error("stored bits not loaded after reset");
   a_reset_quiet: assert property (disable iff (1'b0)
      !reset_n && inReset_r |-> !sdaOe && !memWrEn && !nvmCfgWr && !writeBusy)
      else $error("activity during reset");
   a_oe_rise_low: assert property ($rose(sdaOe) |-> !scl)
      else $error("data pull started with clock high");
   a_busy_bound: assert property (busyCnt_r <= 32'(WRITE_CYCLES + 2))
      else $error("write cycle too long");

   c_prog: cover property (nvmCfgWr);
   c_array_wr: cover property (memWrEn);
   c_locked_ack: cover property (writeLocked && sdaOe);
endmodule : ewl_core_props

// file: bench/ewl_i2c_master.sv
// Two-wire bus master model: serial clock and data pull-down
`timescale 1ns/1ps

module ewl_i2c_master #(
   parameter realtime HALF = 300.3
) (
   output logic scl,
   output logic sdaPull,
   input wire logic sdaWire
);
   // Bus idle: clock stands high, data released
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end

   // Start or repeated start
   task automatic start();
      sdaPull = 1'b0;
      #(HALF) scl = 1'b1;
      #(HALF) sdaPull = 1'b1;
      #(HALF) scl = 1'b0;
      #(HALF / 6);
   endtask : start

   // Stop leaves the device in standby, or in its write cycle after written data
   task automatic stop();
      sdaPull = 1'b1;
      #(HALF) scl = 1'b1;
      #(HALF) sdaPull = 1'b0;
      #(HALF);
   endtask : stop

   // One clock: data set while low, sampled at end of high
   task automatic clockBit(input logic b, output logic s);
      sdaPull = ~b;
      #(HALF) scl = 1'b1;
      #(HALF) s = sdaWire;
      scl = 1'b0;
      #(HALF / 6);
   endtask : clockBit

   // Byte out MSB first, ack read on ninth clock
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clockBit(d[i], s);
      clockBit(1'b1, s);
      ack = ~s;
   endtask : sendByte

   // Byte in, then master ack or nack
   task automatic recvByte(output logic [7:0] d, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clockBit(1'b1, d[i]);
      clockBit(~ack, s);
   endtask : recvByte
endmodule : ewl_i2c_master

// file: bench/eeprom_select_and_write_lock_tb.sv
// Bench for the select-address and write-lock engine
`timescale 1ns/1ps

module eeprom_select_and_write_lock_tb;
   localparam int WCYC = 1000;
   localparam logic [3:0] TYP = ewl_pkg::DEV_TYPE_DEFAULT;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic scl, sdaPull, sdaOut, sdaOe, nvmCfgWr, memWrEn, writeLocked, writeBusy;
   logic [7:0] nvmCell = 8'h00;
   logic [7:0] nvmCfgData, memWrData;
   logic [7:0] mem [0:255];
   logic [15:0] memAddr;
   logic [2:0] selectAddr;
   logic [31:0] rng = 32'h0fb09266;
   int errors = 0;
   int checksDone = 0;
   int wrCount = 0;
   wire sdaWire = ~(sdaOe | sdaPull);

   always #5 mclk = ~mclk;

   // Nonvolatile cells and external array
   always @(posedge mclk) begin
      if (nvmCfgWr) nvmCell <= nvmCfgData;
      if (memWrEn) begin
         mem[memAddr[7:0]] <= memWrData;
         wrCount <= wrCount + 1;
      end
   end

   ewl_core #(.WRITE_CYCLES(WCYC), .DEV_TYPE(TYP)) DUT (
      .mclk(mclk), .reset_n(reset_n), .scl(scl), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .nvmCfgIn(nvmCell), .nvmCfgWr(nvmCfgWr),
      .nvmCfgData(nvmCfgData), .memAddr(memAddr), .memWrData(memWrData),
      .memWrEn(memWrEn), .memRdData(mem[memAddr[7:0]]), .selectAddr(selectAddr),
      .writeLocked(writeLocked), .writeBusy(writeBusy));
   ewl_i2c_master uMst (.scl(scl), .sdaPull(sdaPull), .sdaWire(sdaWire));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : rnd

   // Acknowledge pattern of a four-byte write frame
   function automatic logic [3:0] expWrAcks(input logic toArray, input logic locked);
      return (toArray && locked) ? 4'he : 4'hf;
   endfunction : expWrAcks

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic endOfTest();
      if (errors == 0 && checksDone > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : endOfTest

   // Select, address high (bit 15 picks the register), address low, data
   task automatic wrFrame(input logic [2:0] s, input logic [15:0] a, input logic [7:0] d,
                          output logic [3:0] k);
      uMst.start();
      uMst.sendByte({TYP, s, 1'b0}, k[3]);
      uMst.sendByte(a[15:8], k[2]);
      uMst.sendByte(a[7:0], k[1]);
      uMst.sendByte(d, k[0]);
      uMst.stop();
   endtask : wrFrame

   task automatic rdFrame(input logic [2:0] s, input logic [15:0] a, output logic [7:0] d,
                          output logic [7:0] d2);
      logic [3:0] k;
      uMst.start();
      uMst.sendByte({TYP, s, 1'b0}, k[3]);
      uMst.sendByte(a[15:8], k[2]);
      uMst.sendByte(a[7:0], k[1]);
      uMst.start();
      uMst.sendByte({TYP, s, 1'b1}, k[0]);
      uMst.recvByte(d, 1'b1);
      uMst.recvByte(d2, 1'b0);
      uMst.stop();
   endtask : rdFrame

   task automatic poll(input logic [3:0] t, input logic [2:0] s, output logic ack);
      uMst.start();
      uMst.sendByte({t, s, 1'b0}, ack);
      uMst.stop();
   endtask : poll

   task automatic waitWrite();
      repeat (10) @(negedge mclk);
      for (int i = 0; i < WCYC + 20 && writeBusy !== 1'b0; i++) @(negedge mclk);
      check(writeBusy, 1'b0);
   endtask : waitWrite

   task automatic powerUp();
      @(negedge mclk);
      reset_n = 1'b0;
      repeat (5) @(negedge mclk);
      reset_n = 1'b1;
      repeat (3) @(negedge mclk);
      check({selectAddr, writeLocked}, nvmCell[3:0]);
   endtask : powerUp

   // Main sequence
   initial begin
      logic [3:0] k4;
      logic [7:0] d, cfg, rd, rd2;
      logic [15:0] a;
      logic [2:0] cur;
      logic ack;
      int n;
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
      powerUp();
      poll(TYP, 3'h5, ack);
      check(ack, 1'b0);
      poll(~TYP, 3'h0, ack);
      check(ack, 1'b0);
      cur = 3'h0;
      for (int k = 0; k < 8; k++) begin
         d = 8'(rnd());
         a = 16'(rnd());
         cfg = {d[7:4], 3'(k * 3), k[0]};
         wrFrame(cur, {1'b1, a[14:0]}, cfg, k4);
         check(k4, expWrAcks(1'b0, cfg[0]));
         poll(TYP, cfg[3:1], ack);
         check(ack, 1'b0);
         waitWrite();
         check(nvmCell, cfg);
         check({selectAddr, writeLocked}, cfg[3:0]);
         if (cur != cfg[3:1]) begin
            poll(TYP, cur, ack);
            check(ack, 1'b0);
         end
         cur = cfg[3:1];
         if (k < 2) begin
            rdFrame(cur, {1'b1, a[14:0]}, rd, rd2);
            check(rd, cfg);
            check(rd2, cfg);
         end
         n = wrCount;
         wrFrame(cur, {1'b0, a[14:0]}, d, k4);
         check(k4, expWrAcks(1'b1, cfg[0]));
         check(wrCount - n, cfg[0] ? 0 : 1);
         waitWrite();
         if (k == 0) begin
            rdFrame(cur, {1'b0, a[14:0]}, rd, rd2);
            check(rd, d);
         end
      end
      uMst.start();
      uMst.sendByte({TYP, cur, 1'b0}, ack);
      check(ack, 1'b1);
      @(negedge mclk);
      reset_n = 1'b0;
      uMst.sendByte(8'h80, ack);
      check(ack, 1'b0);
      uMst.stop();
      powerUp();
      poll(TYP, cur, ack);
      check(ack, 1'b1);
      endOfTest();
   end

   // Watchdog
   initial begin
      #900000;
      errors++;
      endOfTest();
   end
endmodule : eeprom_select_and_write_lock_tb

bind ewl_core ewl_core_props #(.WRITE_CYCLES(WRITE_CYCLES)) uProps (
   .mclk(mclk), .reset_n(reset_n), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .nvmCfgIn(nvmCfgIn), .nvmCfgWr(nvmCfgWr), .memAddr(memAddr), .memWrEn(memWrEn),
   .selectAddr(selectAddr), .writeLocked(writeLocked), .writeBusy(writeBusy));
